//--- pkg/drc_defs.vh
`ifndef DRC_DEFS_VH
`define DRC_DEFS_VH

// ************************************************************
// clock rates
// ************************************************************
`define DRC_SYS_HZ 28'h7735940
`define DRC_CORE_HZ 28'h18CBA80
`define DRC_RTC_HZ 28'h0008000

// ************************************************************
// timing
// ************************************************************
// pin debounce, milliseconds
`define DRC_DEBOUNCE_MS 5
// debounce length in core clock ticks, least time so rounded up
`define DRC_DEBOUNCE_TICKS ((`DRC_DEBOUNCE_MS * 26000000 + 999) / 1000)
// synchronous release stages in each domain
`define DRC_RELEASE_STAGES 2

// ************************************************************
// reset values
// ************************************************************
`define DRC_RESET_ASSERTED 1'b1

`endif

//--- src/drc_reset_control.v
// Notes on behaviour
// - two separate reset domains: core (26 MHz logic) and backup (clock, retention memory)
// - any core source resets core: four monitors, pin, software reset, watchdog
// - IO monitor below 2.93 V holds core reset
// - converter input threshold 3.0 V with converter, 1.2 V in bypass mode
// - core monitor below 90% of firmware preset voltage holds core reset
// - backup supply monitor below 0.6V also resets the core domain
// - reset pin low more than 5 ms resets core; shorter pulses ignored
// - firmware software system reset resets the core domain
// - backup reset only from backup monitor, clock soft reset or loss of both IO and battery supply
// - missing main or IO supply holds core reset; no power-up order
// - backup state untouched by main/IO loss or core resets with battery present
// - backup region runs from IO supply, battery only when IO is off
// - no supply keeps backup inactive; a supply arriving resets then releases it
`include "drc_defs.vh"

module drc_reset_control #(
  parameter DEBOUNCE_TICKS = `DRC_DEBOUNCE_TICKS,
  parameter RELEASE_STAGES = `DRC_RELEASE_STAGES
) (
  input wire sys_clk,
  input wire reset,
  input wire main_supply_present,
  input wire io_supply_present,
  input wire battery_supply_present,
  input wire io_monitor_low,
  input wire converter_bypass_mode,
  input wire converter_input_monitor_low_conv,
  input wire converter_input_monitor_low_bypass,
  input wire core_monitor_low,
  input wire backup_supply_monitor_low,
  input wire reset_pin_n,
  input wire sw_system_reset,
  input wire watchdog_expired,
  input wire rtc_soft_reset,
  output reg core_reset,
  output reg backup_reset,
  output reg backup_active,
  output reg backup_on_battery,
  output reg pin_reset_active,
  output reg core_tick,
  output reg rtc_tick
);

  // ************************************************************
  // helpers
  // ************************************************************
  // phase accumulator step for fractional dividers
  function [28:0] drc_phase_step;
    input [27:0] acc;
    input [27:0] inc;
    reg [28:0] sum;
    begin
      sum = {1'b0, acc} + {1'b0, inc};
      if (sum >= {1'b0, `DRC_SYS_HZ}) begin
        drc_phase_step = {1'b1, sum[27:0] - `DRC_SYS_HZ};
      end else begin
        drc_phase_step = {1'b0, sum[27:0]};
      end
    end
  endfunction

  // ************************************************************
  // tick dividers
  // ************************************************************
  reg [27:0] core_phase;
  reg [27:0] rtc_phase;
  wire [28:0] next_core_phase;
  wire [28:0] next_rtc_phase;

  assign next_core_phase = drc_phase_step(core_phase, `DRC_CORE_HZ);
  assign next_rtc_phase = drc_phase_step(rtc_phase, `DRC_RTC_HZ);

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      core_phase <= 28'h0000000;
      rtc_phase <= 28'h0000000;
      core_tick <= 1'b0;
      rtc_tick <= 1'b0;
    end else begin
      core_phase <= next_core_phase[27:0];
      rtc_phase <= next_rtc_phase[27:0];
      core_tick <= next_core_phase[28];
      rtc_tick <= next_rtc_phase[28];
    end
  end

  // ************************************************************
  // reset pin debounce
  // ************************************************************
  reg [31:0] low_count;

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      low_count <= 32'h00000000;
      pin_reset_active <= 1'b0;
    end else if (reset_pin_n) begin
      low_count <= 32'h00000000;
      pin_reset_active <= 1'b0;
    end else if (core_tick) begin
      // count only on core ticks, saturate past the limit
      if (low_count <= DEBOUNCE_TICKS) begin
        low_count <= low_count + 32'h00000001;
      end
      if (low_count >= DEBOUNCE_TICKS) begin
        pin_reset_active <= 1'b1;
      end
    end
  end

  // ************************************************************
  // core domain
  // ************************************************************
  wire converter_low;
  wire supply_missing;
  wire core_request;

  assign converter_low = converter_bypass_mode ? converter_input_monitor_low_bypass :
                         converter_input_monitor_low_conv;
  assign supply_missing = !main_supply_present || !io_supply_present;
  assign core_request = io_monitor_low || converter_low || core_monitor_low ||
                        backup_supply_monitor_low || pin_reset_active ||
                        sw_system_reset || watchdog_expired || supply_missing;

  reg [RELEASE_STAGES-1:0] core_hold;

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      core_hold <= {RELEASE_STAGES{1'b1}};
      core_reset <= `DRC_RESET_ASSERTED;
    end else if (core_request) begin
      core_hold <= {RELEASE_STAGES{1'b1}};
      core_reset <= 1'b1;
    end else if (core_tick) begin
      // release only after the sources have been quiet for the stages
      core_hold <= core_hold >> 1;
      core_reset <= core_hold[0];
    end
  end

  // ************************************************************
  // backup domain
  // ************************************************************
  wire backup_unpowered;
  wire backup_request;

  assign backup_unpowered = !io_supply_present && !battery_supply_present;
  // only own sources; core sources and main supply are not listed here
  assign backup_request = backup_supply_monitor_low || rtc_soft_reset ||
                          backup_unpowered;

  reg [RELEASE_STAGES-1:0] backup_hold;

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      backup_hold <= {RELEASE_STAGES{1'b1}};
      backup_reset <= `DRC_RESET_ASSERTED;
      backup_active <= 1'b0;
      backup_on_battery <= 1'b0;
    end else begin
      backup_active <= !backup_unpowered;
      backup_on_battery <= !io_supply_present && battery_supply_present;
      if (backup_request) begin
        backup_hold <= {RELEASE_STAGES{1'b1}};
        backup_reset <= 1'b1;
      end else if (rtc_tick) begin
        backup_hold <= backup_hold >> 1;
        backup_reset <= backup_hold[0];
      end
    end
  end

endmodule // drc_reset_control

//--- verif/drc_supply_model.sv
module drc_supply_model (
  input wire sys_clk,
  input wire [2:0] want,
  output logic main_supply_present = 1'h1,
  output logic io_supply_present = 1'h1,
  output logic battery_supply_present = 1'h1
);
  timeunit 1ns;
  timeprecision 1ps;
  // supplies come and go in any order, each on its own
  // power stays up well past the start-up time before any removal
  // straps are outside this block, taken as pulled high
  // watchdog source held quiet except where a test raises it
  always @(negedge sys_clk)
    {main_supply_present, io_supply_present, battery_supply_present} <= want;
endmodule // drc_supply_model

//--- verif/drc_checker.sv
module drc_checker (
  input wire sys_clk,
  input wire reset,
  input wire main_supply_present,
  input wire io_supply_present,
  input wire battery_supply_present,
  input wire io_monitor_low,
  input wire backup_supply_monitor_low,
  input wire sw_system_reset,
  input wire watchdog_expired,
  input wire rtc_soft_reset,
  input wire core_reset,
  input wire backup_reset,
  input wire backup_on_battery,
  input wire pin_reset_active,
  input wire core_tick,
  input wire rtc_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_sw_core: assert property (sw_system_reset |=> core_reset) else $error("sw");
  a_wd_core: assert property (watchdog_expired |=> core_reset) else $error("wd");
  a_io_core: assert property (io_monitor_low |=> core_reset) else $error("io");
  a_bk_mon: assert property (backup_supply_monitor_low |=> core_reset && backup_reset)
    else $error("bkmon");
  a_supply_loss: assert property (!(main_supply_present && io_supply_present) |=> core_reset)
    else $error("supply");
  a_on_batt: assert property (1 |=>
    backup_on_battery == $past(!io_supply_present && battery_supply_present)) else $error("batt");
  a_pin_core: assert property ($rose(pin_reset_active) |=> core_reset) else $error("pin");
  a_core_rel: assert property ($fell(core_reset) |->
    ($past(core_tick) || core_tick) && !$past(sw_system_reset)) else $error("crel");
  a_bk_rel: assert property ($fell(backup_reset) |->
    ($past(rtc_tick) || rtc_tick) && !$past(rtc_soft_reset)) else $error("brel");
  a_bk_cause: assert property ($rose(backup_reset) |-> $past(backup_supply_monitor_low ||
    rtc_soft_reset || !(io_supply_present || battery_supply_present))) else $error("bcause");
endmodule // drc_checker
bind drc_reset_control drc_checker drc_checker_inst (.*);

//--- verif/test_dual_domain_reset_control.sv
module test_dual_domain_reset_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, reset = 1, reset_pin_n = 1, converter_bypass_mode = 0, rtc_soft_reset = 0;
  logic backup_supply_monitor_low = 0;
  logic [5:0] src = 6'h00;
  logic [2:0] want = 3'h7;
  logic sw_system_reset, watchdog_expired, io_monitor_low, core_monitor_low;
  logic converter_input_monitor_low_conv, converter_input_monitor_low_bypass;
  wire main_supply_present, io_supply_present, battery_supply_present, core_reset, backup_reset;
  wire backup_active, backup_on_battery, pin_reset_active, core_tick, rtc_tick;
  int n_mismatch = 0, samples_checked = 0, cycles = 0;
  assign {sw_system_reset, watchdog_expired, io_monitor_low, core_monitor_low,
    converter_input_monitor_low_conv, converter_input_monitor_low_bypass} = src;
  drc_supply_model drc_supply_model_inst (.*);
  drc_reset_control #(.DEBOUNCE_TICKS(8)) drc_reset_control_inst (.*);
  always #4 sys_clk = ~sys_clk;
  task chk(input string nm, input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", nm, exp, seen);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task wait_rel(input string nm, input bit bk, input int lim);
    for (int i = 0; i < lim && (bk ? backup_reset : core_reset) !== 1'h0; i++) cyc(1);
    chk(nm, bk ? backup_reset : core_reset, 1'h0);
  endtask
  task t_core;
    for (int k = 0; k < 6; k++) begin
      src = 6'h01 << k;
      converter_bypass_mode = (k == 0);
      cyc(3);
      chk("core src", core_reset, 1'h1);
      chk("bk src", backup_reset, 1'h0);
      src = 6'h00;
      wait_rel("core rel", 0, 200);
    end
    converter_bypass_mode = 1;
    src = 6'h02;
    cyc(3);
    chk("mode", core_reset, 1'h0);
    src = 6'h00;
    converter_bypass_mode = 0;
    $display("t_core done");
  endtask
  task t_pin(input int n, input logic exp);
    reset_pin_n = 0;
    repeat (n) @(posedge core_tick);
    cyc(3);
    chk("pin", pin_reset_active, exp);
    chk("pin core", core_reset, exp);
    reset_pin_n = 1;
    wait_rel("pin rel", 0, 200);
    $display("t_pin done");
  endtask
  task t_backup;
    rtc_soft_reset = 1;
    cyc(3);
    chk("soft bk", backup_reset, 1'h1);
    chk("soft core", core_reset, 1'h0);
    rtc_soft_reset = 0;
    wait_rel("bk rel", 1, 12000);
    backup_supply_monitor_low = 1;
    cyc(3);
    chk("mon bk", backup_reset, 1'h1);
    backup_supply_monitor_low = 0;
    wait_rel("mon rel", 0, 200);
    wait_rel("mon bk rel", 1, 12000);
    want = 3'h1;
    cyc(3);
    chk("batt", backup_on_battery, 1'h1);
    chk("loss core", core_reset, 1'h1);
    chk("loss bk", backup_reset, 1'h0);
    want = 3'h0;
    cyc(3);
    chk("dead", backup_active, 1'h0);
    want = 3'h2;
    cyc(3);
    chk("up bk", backup_reset, 1'h1);
    chk("io feed", backup_on_battery, 1'h0);
    want = 3'h7;
    wait_rel("up rel", 1, 12000);
    $display("t_backup done");
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 80000) begin
      n_mismatch++;
      end_sim;
    end
  end
  initial begin
    cyc(5);
    reset = 0;
    wait_rel("init", 0, 200);
    wait_rel("init bk", 1, 12000);
    t_core;
    t_pin(8, 1'h0);
    t_pin(10, 1'h1);
    t_backup;
    end_sim;
  end
endmodule // test_dual_domain_reset_control
